// ---- rtl/uv_fault_ctrl.v ----
// Under-voltage fault response controller with its configuration registers
`timescale 1ns/1ps
`include "uv_fault_defs.vh"

module uv_fault_ctrl #(
   parameter MS_CYCLES = `MS_CYCLES_DFLT,
   parameter TMR_W     = 16,
   parameter UV_CNT_W  = 5
) (
   // Clock and reset
   input  wire       clk,
   input  wire       rst,
   // Register port from the serial interface
   input  wire       reg_wr,
   input  wire       reg_rd,
   input  wire [7:0] reg_addr,
   input  wire [7:0] reg_wdata,
   output reg  [7:0] reg_rdata_r,
   // Converter and protection inputs
   input  wire       en_pin,
   input  wire       sw_tick,
   input  wire       uv_comp_raw,
   input  wire       oc_trip,
   input  wire       oc_latch_sel,
   input  wire       ot_trip,
   input  wire       ss_done,
   // Converter controls
   output reg        switching_en_r,
   output reg        cur_limit_en_r,
   output reg        ss_start_r,
   output reg        uv_threshold_sel_r,
   output reg        latched_off_r
);

   localparam [5:0] ST_OFF   = 6'h01;
   localparam [5:0] ST_SS    = 6'h02;
   localparam [5:0] ST_RUN   = 6'h04;
   localparam [5:0] ST_WAIT  = 6'h08;
   localparam [5:0] ST_LATCH = 6'h10;
   localparam [5:0] ST_OT    = 6'h20;

   ////////////////////////////////////////////////////////////////////////////////
   // Registers

   reg  [7:0] ovp_cfg_r;
   reg  [7:0] uvp_cfg_r;
   reg        uv_sticky_r;
   reg        oc_sticky_r;
   reg        hiccup_r;
   reg        retry_r;
   reg  [5:0] state_r;
   reg  [5:0] state_nxt;
   reg  [TMR_W-1:0] tick_r;
   reg  [4:0] ms_r;
   reg        uv_fault_act;
   reg        oc_fault_act;
   reg        fault_latch;
   reg  [7:0] stat;

   wire       uv_trip;
   wire       uv_live;
   wire [1:0] uv_mode    = uvp_cfg_r[`UVP_MODE_HI:`UVP_MODE_LO];
   wire [1:0] hiccup_sel = uvp_cfg_r[`UVP_HICCUP_HI:`UVP_HICCUP_LO];
   wire [4:0] ms_target  = 5'h01 << ({1'b0, hiccup_sel} + 3'd1);
   wire       tick_end   = (tick_r == MS_CYCLES[TMR_W-1:0] - {{(TMR_W-1){1'b0}}, 1'b1});
   wire       wait_done  = tick_end && (ms_r + 5'h01 == ms_target);
   wire       stat_clr   = reg_wr && (reg_addr == `FAULT_STAT_ADDR);

   always @(posedge clk) begin
      if (rst) begin
         ovp_cfg_r <= `OVP_CFG_RST;
         uvp_cfg_r <= `UVP_CFG_RST;
      end else if (reg_wr) begin
         if (reg_addr == `OVP_CFG_ADDR) begin
            ovp_cfg_r <= reg_wdata;
         end
         if (reg_addr == `UVP_CFG_ADDR) begin
            uvp_cfg_r <= reg_wdata;
         end
      end
   end

   always @* begin
      stat                  = 8'h00;
      stat[`STAT_UV_STICKY] = uv_sticky_r;
      stat[`STAT_OC_STICKY] = oc_sticky_r;
      stat[`STAT_HICCUP]    = hiccup_r;
      stat[`STAT_LATCHED]   = latched_off_r;
      stat[`STAT_SWITCHING] = switching_en_r;
      stat[`STAT_SOFTSTART] = (state_r == ST_SS);
      stat[`STAT_UV_LIVE]   = uv_live;
   end

   always @(posedge clk) begin
      if (rst) begin
         reg_rdata_r <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `OVP_CFG_ADDR:    reg_rdata_r <= ovp_cfg_r;
            `UVP_CFG_ADDR:    reg_rdata_r <= uvp_cfg_r;
            `FAULT_STAT_ADDR: reg_rdata_r <= stat;
            default:          reg_rdata_r <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Qualification

   uv_qualifier #(
      .CNT_W (UV_CNT_W)
   ) u_qual (
      .clk            (clk),
      .rst            (rst),
      .arm            (state_r == ST_RUN),
      .sw_tick        (sw_tick),
      .count_sel      (uvp_cfg_r[`UVP_COUNT_HI:`UVP_COUNT_LO]),
      .uv_comp_raw    (uv_comp_raw),
      .uv_live        (uv_live),
      .uv_qualified_r (uv_trip)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Fault arbitration and sequencing

   always @* begin
      uv_fault_act = 1'b0;
      oc_fault_act = 1'b0;
      fault_latch  = 1'b0;
      if (uv_trip) begin
         // UV owns the response even in no-response mode
         uv_fault_act = (uv_mode == `UV_MODE_RECOVER) || (uv_mode == `UV_MODE_LATCH);
         fault_latch  = (uv_mode == `UV_MODE_LATCH);
      end else if (oc_trip) begin
         oc_fault_act = 1'b1;
         fault_latch  = oc_latch_sel;
      end
   end

   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_OFF:   if (en_pin && !ot_trip) state_nxt = ST_SS;
         ST_SS:    if (ss_done) state_nxt = ST_RUN;
         ST_RUN: begin
            if (uv_fault_act || oc_fault_act) begin
               state_nxt = fault_latch ? ST_LATCH : ST_WAIT;
            end
         end
         ST_WAIT:  if (wait_done) state_nxt = ST_SS;
         ST_LATCH: state_nxt = ST_LATCH;
         ST_OT:    if (!ot_trip) state_nxt = ST_SS;
         default:  state_nxt = ST_OFF;
      endcase
      if (!en_pin) begin
         state_nxt = ST_OFF;
      end else if (ot_trip && state_nxt != ST_LATCH && state_nxt != ST_OFF) begin
         state_nxt = ST_OT;
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         state_r            <= ST_OFF;
         tick_r             <= {TMR_W{1'b0}};
         ms_r               <= 5'h00;
         retry_r            <= 1'b0;
         hiccup_r           <= 1'b0;
         uv_sticky_r        <= 1'b0;
         oc_sticky_r        <= 1'b0;
         switching_en_r     <= 1'b0;
         cur_limit_en_r     <= 1'b0;
         ss_start_r         <= 1'b0;
         latched_off_r      <= 1'b0;
         uv_threshold_sel_r <= 1'b0;
      end else begin
         state_r            <= state_nxt;
         uv_threshold_sel_r <= uvp_cfg_r[`UVP_THRESH_BIT];
         switching_en_r     <= (state_nxt == ST_SS) || (state_nxt == ST_RUN);
         cur_limit_en_r     <= (state_nxt == ST_SS) || (state_nxt == ST_RUN);
         ss_start_r         <= (state_nxt == ST_SS) && (state_r != ST_SS);
         latched_off_r      <= (state_nxt == ST_LATCH);
         if (state_r == ST_WAIT && !tick_end) begin
            tick_r <= tick_r + {{(TMR_W-1){1'b0}}, 1'b1};
         end else begin
            tick_r <= {TMR_W{1'b0}};
         end
         if (state_r != ST_WAIT) begin
            ms_r <= 5'h00;
         end else if (tick_end) begin
            ms_r <= ms_r + 5'h01;
         end
         if (state_nxt == ST_OFF) begin
            retry_r  <= 1'b0;
            hiccup_r <= 1'b0;
         end else if (state_r == ST_RUN && state_nxt == ST_WAIT) begin
            retry_r <= 1'b1;
            if (retry_r) begin
               hiccup_r <= 1'b1;
            end
         end
         // Hardware set wins over a status write in the same cycle
         if (uv_trip) begin
            uv_sticky_r <= 1'b1;
         end else if (stat_clr && reg_wdata[`STAT_UV_STICKY]) begin
            uv_sticky_r <= 1'b0;
         end
         if (oc_trip && state_r == ST_RUN) begin
            oc_sticky_r <= 1'b1;
         end else if (stat_clr && reg_wdata[`STAT_OC_STICKY]) begin
            oc_sticky_r <= 1'b0;
         end
      end
   end

endmodule // uv_fault_ctrl

// ---- rtl/uv_fault_defs.vh ----
// Register map, field positions, reset values and timing for the under-voltage fault logic
`ifndef UV_FAULT_DEFS_VH
`define UV_FAULT_DEFS_VH

// Register addresses
`define OVP_CFG_ADDR      8'h0d
`define UVP_CFG_ADDR      8'h0c
`define FAULT_STAT_ADDR   8'h10

// Reset values
`define OVP_CFG_RST       8'h00
`define UVP_CFG_RST       8'h00

// Under-voltage configuration fields
`define UVP_HICCUP_HI     6
`define UVP_HICCUP_LO     5
`define UVP_THRESH_BIT    4
`define UVP_COUNT_HI      3
`define UVP_COUNT_LO      2
`define UVP_MODE_HI       1
`define UVP_MODE_LO       0

// Response codes
`define UV_MODE_RECOVER   2'h0
`define UV_MODE_LATCH     2'h1

// Fault status bits
`define STAT_UV_STICKY    0
`define STAT_OC_STICKY    1
`define STAT_HICCUP       2
`define STAT_LATCHED      3
`define STAT_SWITCHING    4
`define STAT_SOFTSTART    5
`define STAT_UV_LIVE      6

// Timing
`define CLK_PERIOD_PS     25000
`define DELAY_UNIT_PS     1000000000
`define MS_CYCLES_DFLT    (`DELAY_UNIT_PS / `CLK_PERIOD_PS)

`endif

// ---- rtl/uv_qualifier.v ----
// Under-voltage comparator synchroniser and consecutive switching-period qualifier
`timescale 1ns/1ps
`include "uv_fault_defs.vh"

module uv_qualifier #(
   parameter CNT_W = 5
) (
   // Clock and reset
   input  wire       clk,
   input  wire       rst,
   // Control
   input  wire       arm,
   input  wire       sw_tick,
   input  wire [1:0] count_sel,
   // Comparator
   input  wire       uv_comp_raw,
   // Result
   output wire       uv_live,
   output reg        uv_qualified_r
);

   reg              sync1_r;
   reg              sync2_r;
   reg  [CNT_W-1:0] cnt_r;
   wire [CNT_W-1:0] target;

   // 00 gives 2, 01 gives 4, 02 gives 8, 03 gives 16
   assign target  = {{(CNT_W-1){1'b0}}, 1'b1} << ({1'b0, count_sel} + 3'd1);
   assign uv_live = sync2_r;

   always @(posedge clk) begin
      if (rst) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
      end else begin
         sync1_r <= uv_comp_raw;
         sync2_r <= sync1_r;
      end
   end

   always @(posedge clk) begin
      if (rst || !arm) begin
         cnt_r          <= {CNT_W{1'b0}};
         uv_qualified_r <= 1'b0;
      end else if (!sync2_r) begin
         cnt_r          <= {CNT_W{1'b0}};
         uv_qualified_r <= 1'b0;
      end else if (sw_tick && !uv_qualified_r) begin
         if (cnt_r + {{(CNT_W-1){1'b0}}, 1'b1} == target) begin
            uv_qualified_r <= 1'b1;
         end
         cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end

endmodule // uv_qualifier

// ---- tb/uv_fault_checks_asserts.sv ----
// Port checks for the under-voltage fault controller
`timescale 1ns/1ps
module uv_fault_checks (
   // Clock and reset
   input wire       clk,
   input wire       rst,
   // Register port
   input wire       reg_wr,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   // Converter
   input wire       en_pin,
   input wire       switching_en_r,
   input wire       cur_limit_en_r,
   input wire       ss_start_r,
   input wire       uv_threshold_sel_r,
   input wire       latched_off_r
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_limit_tracks_sw: assert property (cur_limit_en_r == switching_en_r)
      else $error("current limit not following switching");
   a_ss_one_pulse: assert property (ss_start_r |=> !ss_start_r)
      else $error("soft start pulse too long");
   a_ss_sw_on: assert property (ss_start_r |-> switching_en_r)
      else $error("soft start without switching");
   a_restart_via_ss: assert property ($rose(switching_en_r) |-> ss_start_r)
      else $error("switching resumed without soft start");
   a_latch_no_sw: assert property (latched_off_r |-> !switching_en_r)
      else $error("switching while latched");
   a_latch_holds: assert property (latched_off_r && en_pin |=> latched_off_r)
      else $error("latch released with enable high");
   a_en_low_off: assert property (!en_pin |=> !switching_en_r && !latched_off_r)
      else $error("enable low did not stop");
   a_thresh_copy: assert property (reg_wr && reg_addr == 8'h0c
      |-> ##2 uv_threshold_sel_r == $past(reg_wdata[4], 2)) else $error("threshold not copied");
   cover property (latched_off_r);
   cover property ($fell(switching_en_r) && en_pin);
   cover property (ss_start_r ##[2:60] ss_start_r);
endmodule // uv_fault_checks
bind uv_fault_ctrl uv_fault_checks i_chk (.*);

// ---- tb/reg_host.sv ----
// Host model driving the register port
`timescale 1ns/1ps
module reg_host (
   // Clock
   input  wire       clk,
   // Register port
   output reg        reg_wr,
   output reg        reg_rd,
   output reg  [7:0] reg_addr,
   output reg  [7:0] reg_wdata,
   input  wire [7:0] reg_rdata_r
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'hff;
      reg_wdata = 8'h00;
   end
   task wr(input [7:0] a, input [7:0] v);
      begin
         @(posedge clk);
         reg_wr <= 1'b1;
         reg_addr <= a;
         reg_wdata <= v;
         @(posedge clk);
         reg_wr <= 1'b0;
         reg_addr <= ~a;
         reg_wdata <= ~v;
      end
   endtask
   task rd(input [7:0] a, output [7:0] v);
      begin
         @(posedge clk);
         reg_rd <= 1'b1;
         reg_addr <= a;
         @(posedge clk);
         reg_rd <= 1'b0;
         reg_addr <= ~a;
         #1 v = reg_rdata_r;
      end
   endtask
endmodule // reg_host

// ---- tb/testbench.sv ----
// Self-checking bench for the under-voltage fault controller
`timescale 1ns/1ps
module testbench;
   localparam MS = 4;
   reg clk, rst, en_pin, sw_tick, uv_comp_raw, oc_trip, oc_latch_sel, ot_trip, ss_done;
   wire reg_wr, reg_rd, sw, cl, ssp, ths, lat;
   wire [7:0] reg_addr, reg_wdata, rdata;
   integer err_count, checks_done, seed, i, c;
   reg [7:0] d, v;
   reg_host h (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata_r(rdata));
   uv_fault_ctrl #(.MS_CYCLES(MS)) i_dut (.clk(clk), .rst(rst), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(rdata),
      .en_pin(en_pin), .sw_tick(sw_tick), .uv_comp_raw(uv_comp_raw), .oc_trip(oc_trip),
      .oc_latch_sel(oc_latch_sel), .ot_trip(ot_trip), .ss_done(ss_done),
      .switching_en_r(sw), .cur_limit_en_r(cl), .ss_start_r(ssp),
      .uv_threshold_sel_r(ths), .latched_off_r(lat));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   function integer n_cnt(input integer k);
      n_cnt = 2 << k;
   endfunction
   task chk(input [7:0] seen, input [7:0] exp);
      begin
         checks_done = checks_done + 1;
         if (seen !== exp) begin
            err_count = err_count + 1;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task give_verdict;
      begin
         $display("checks %0d errors %0d", checks_done, err_count);
         if (err_count == 0 && checks_done > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   task cyc(input integer n);
      repeat (n) @(posedge clk);
   endtask
   task tk(input integer n);
      repeat (n) begin
         @(posedge clk) sw_tick <= 1'b1;
         @(posedge clk) sw_tick <= 1'b0;
      end
   endtask
   task uv(input b);
      begin
         @(posedge clk) uv_comp_raw <= b;
         cyc(3);
      end
   endtask
   task en_on;
      begin
         @(posedge clk) en_pin <= 1'b1;
         @(posedge clk) #1 chk(ssp, 1'b1);
         chk(cl, 1'b1);
      end
   endtask
   task run;
      begin
         @(posedge clk) ss_done <= 1'b1;
         @(posedge clk) ss_done <= 1'b0;
      end
   endtask
   task st(input integer b, input e);
      begin
         h.rd(8'h10, d);
         chk(d[b], e);
      end
   endtask
   task trip(input integer n);
      begin
         tk(n);
         cyc(2);
         #1 chk(sw, 1'b0);
      end
   endtask
   initial begin
      #(25 * 6000);
      err_count = err_count + 1;
      give_verdict;
   end
   initial begin
      seed = 32'he8a0847d;
      err_count = 0;
      checks_done = 0;
      {rst, en_pin, sw_tick, uv_comp_raw, oc_trip, oc_latch_sel, ot_trip, ss_done} = 8'h80;
      cyc(4);
      rst <= 1'b0;
      h.rd(8'h0c, d);
      chk(d, 8'h00);
      h.rd(8'h3f, d);
      chk(d, 8'h00);
      for (i = 0; i < 4; i = i + 1) begin
         v = $random(seed);
         h.wr(8'h0d, v);
         h.rd(8'h0d, d);
         chk(d, v);
      end
      h.wr(8'h0c, 8'h02);
      en_on;
      uv(1);
      tk(4);
      st(0, 1'b0);
      run;
      for (c = 0; c < 4; c = c + 1) begin
         uv(0);
         h.wr(8'h0c, {3'h0, c[0], c[1:0], 1'b1, c[1]});
         h.wr(8'h10, 8'h01);
         chk(ths, c[0]);
         uv(1);
         tk(n_cnt(c) - 1);
         st(0, 1'b0);
         tk(1);
         cyc(3);
         st(0, 1'b1);
         chk(sw, 1'b1);
      end
      uv(0);
      h.wr(8'h0c, 8'h06);
      h.wr(8'h10, 8'h01);
      uv(1);
      tk(3);
      uv(0);
      uv(1);
      tk(3);
      st(0, 1'b0);
      tk(1);
      cyc(2);
      oc_latch_sel <= 1'b1;
      cyc(3);
      chk(sw, 1'b1);
      oc_trip <= 1'b1;
      cyc(4);
      chk({sw, lat}, 2'b10);
      oc_trip <= 1'b0;
      oc_latch_sel <= 1'b0;
      ot_trip <= 1'b1;
      cyc(3);
      chk(sw, 1'b0);
      ot_trip <= 1'b0;
      cyc(3);
      chk(sw, 1'b1);
      run;
      uv(0);
      h.wr(8'h0c, 8'h00);
      uv(1);
      trip(2);
      i = 0;
      while (ssp !== 1'b1 && i < 40) begin
         @(posedge clk) #1 i = i + 1;
      end
      chk(i, MS * 2 - 1);
      run;
      trip(2);
      st(2, 1'b1);
      @(posedge clk) en_pin <= 1'b0;
      h.wr(8'h0c, 8'h01);
      en_on;
      run;
      trip(2);
      chk(lat, 1'b1);
      cyc(20);
      chk({sw, lat}, 2'b01);
      en_pin <= 1'b0;
      cyc(2);
      chk(lat, 1'b0);
      en_on;
      give_verdict;
   end
endmodule // testbench
